/* File: dv/adc_result_format_config_bench.sv */
// Purpose: Self-checking bench for configuration and result formatting
// Assumes: Registered read data, one-cycle write strobe
// Notes: Expected result bytes come from an integer model
`timescale 1ns/1ps
`default_nettype none
module adc_result_format_config_bench import adc_fmt_pkg::*;;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic go = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [9:0] code = 10'h000;
  logic [7:0] rdata;
  logic [9:0] conv_code;
  logic start_conv, tick, unity, busy, done;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int last_tick = 0;
  int gap = 0;
  int nticks = 0;
  // Busy one cycle late lines up with the registered tick output
  logic busy_d = 1'b0;
  logic [15:0] exp_q [$];
  logic [7:0] rst_val [4] = '{RST_CONFIG, RST_RES_LOW, RST_RES_HIGH, 8'h00};
  logic [31:0] seed = 32'h00000061;
  always #2.5 clock = ~clock;
  adc_result_format_config DUT (.CLOCK(clock), .RESETN(resetn),
    .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WE(we), .SFR_RE(re),
    .SFR_RDATA(rdata), .START_CONV(start_conv), .CONV_CODE(conv_code),
    .STEP_TICK(tick), .UNITY_GAIN(unity), .CONV_BUSY(busy),
    .CONV_DONE(done));
  conv_core_model core (.clock(clock), .go(go), .code(code), .done(done),
    .start_conv(start_conv), .conv_code(conv_code));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Mode 0 right, 1 left, 2 eight-bit
  function automatic logic [15:0] fmt(input int c, input int m);
    if (m == 2)
      return (c >> 2) << 8;
    if (m == 1)
      return c << 6;
    return c;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    addr = a;
    wdata = d;
    we = 1'b1;
    @(posedge clock) #1;
    we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) #1;
    addr = a;
    re = 1'b1;
    @(posedge clock) #1;
    re = 1'b0;
    d = rdata;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (tick === 1'b1) begin
      gap = cycles - last_tick;
      last_tick = cycles;
    end
    if (tick === 1'b1 && busy_d === 1'b1)
      nticks++;
    busy_d = busy;
    if (cycles > 20000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    logic [7:0] d, h;
    int m, div;
    repeat (4) @(posedge clock);
    #1 resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(OFS_CONFIG + 8'(i), d);
      check(d, rst_val[i]);
    end
    check(unity, 1'b1);
    wr(OFS_RES_LOW, 8'h5A);
    rd(OFS_RES_LOW, d);
    check(d, 8'h5A);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      m = i % 3;
      div = seed[2:0];
      code = seed[17:8];
      wr(OFS_CONFIG, {5'(div), m == 1 || (m == 2 && seed[20]), m == 2,
        seed[21]});
      @(posedge clock) #1;
      check(unity, seed[21]);
      repeat (80) @(posedge clock);
      #1;
      check(gap, div + 1);
      nticks = 0;
      exp_q.push_back(fmt(code, m));
      go = 1'b1;
      @(posedge clock) #1;
      go = 1'b0;
      @(posedge clock) #1;
      check(busy, 1'b1);
      for (int n = 0; n < 400 && done !== 1'b1; n++)
        @(posedge clock) #1;
      check(done, 1'b1);
      check(busy, 1'b0);
      rd(OFS_RES_HIGH, h);
      rd(OFS_RES_LOW, d);
      check(nticks, m == 2 ? 8 : 10);
      check({h, d}, exp_q.pop_front());
    end
    stop_test();
  end
endmodule
`default_nettype wire

/* File: dv/conv_core_model.sv */
// Purpose: Conversion core stand-in giving start pulse and result code
// Assumes: Code must stay valid until the block reports completion
// Notes: Code lines show an inverted code once the result has loaded
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
  input wire logic clock,
  input wire logic go,
  input wire logic [9:0] code,
  input wire logic done,
  output logic start_conv,
  output logic [9:0] conv_code
);
  always @(posedge clock) begin
    start_conv <= #1 go;
    if (go)
      conv_code <= #1 code;
    else if (done)
      conv_code <= #1 ~code;
  end
endmodule
`default_nettype wire

/* File: rtl/adc_fmt_pkg.sv */
// Purpose: Shared constants and types for the converter format block
// Assumes: 8-bit special-function register bus, 10-bit result code
// Notes: Register offsets are byte addresses on the register bus
package adc_fmt_pkg;
  localparam logic [7:0] OFS_CONFIG = 8'hBC;
  localparam logic [7:0] OFS_RES_LOW = 8'hBD;
  localparam logic [7:0] OFS_RES_HIGH = 8'hBE;
  localparam logic [7:0] RST_CONFIG = 8'hF9;
  localparam logic [7:0] RST_RES_LOW = 8'h00;
  localparam logic [7:0] RST_RES_HIGH = 8'h00;
  localparam int POS_DIV_LSB = 3;
  localparam int POS_LJST = 2;
  localparam int POS_8BIT = 1;
  localparam int POS_GAIN = 0;
  localparam int CODE_W = 10;
  localparam logic [4:0] STEPS_10BIT = 5'h0A;
  localparam logic [4:0] STEPS_SHORTER_8BIT = 5'h02;

  typedef struct packed {
    logic [4:0] divisor;
    logic left_justify;
    logic eight_bit;
    logic gain;
  } config_s;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_s;
endpackage

/* File: rtl/adc_result_format_config.sv */
// Purpose: Converter configuration register and result byte formatting
// Assumes: Conversion core raises START_CONV for one cycle to begin
// Notes: Busy stays high for the step count of the selected resolution
`timescale 1ns/1ps
`default_nettype none
module adc_result_format_config
  import adc_fmt_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  output logic [7:0] SFR_RDATA,
  input wire logic START_CONV,
  input wire logic [9:0] CONV_CODE,
  output logic STEP_TICK,
  output logic UNITY_GAIN,
  output logic CONV_BUSY,
  output logic CONV_DONE
);
  config_s cfg;
  result_s res;
  logic [4:0] steps_left;
  logic step_tick;

  step_clock_divider u_div (
    .clock(CLOCK),
    .resetn(RESETN),
    .divisor(cfg.divisor),
    .step_tick(step_tick)
  );

  wire sel_cfg = (SFR_ADDR == OFS_CONFIG);
  wire sel_low = (SFR_ADDR == OFS_RES_LOW);
  wire sel_high = (SFR_ADDR == OFS_RES_HIGH);
  wire cfg_we = SFR_WE && sel_cfg;
  wire low_we = SFR_WE && sel_low;
  wire high_we = SFR_WE && sel_high;

  wire [4:0] steps_total = cfg.eight_bit ?
    5'(STEPS_10BIT - STEPS_SHORTER_8BIT) : STEPS_10BIT;
  wire finishing = CONV_BUSY && step_tick && (steps_left == 5'h01);

  // Formatting: justification only counts in 10-bit mode
  result_s fmt_right;
  result_s fmt_left;
  result_s fmt_eight;
  assign fmt_right = {6'h00, CONV_CODE[9:8], CONV_CODE[7:0]};
  assign fmt_left = {CONV_CODE[9:2], CONV_CODE[1:0], 6'h00};
  assign fmt_eight = {CONV_CODE[9:2], 8'h00};
  result_s fmt;
  assign fmt = cfg.eight_bit ? fmt_eight :
    (cfg.left_justify ? fmt_left : fmt_right);

  wire [7:0] rd_mux = sel_cfg ? cfg :
    (sel_low ? res.low : (sel_high ? res.high : 8'h00));
  wire [4:0] next_steps = (START_CONV && !CONV_BUSY) ? steps_total :
    ((CONV_BUSY && step_tick) ? 5'(steps_left - 5'h01) : steps_left);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cfg <= RST_CONFIG;
    end else if (cfg_we) begin
      cfg <= SFR_WDATA;
    end
  end

  // Completion load wins over a software write in the same cycle
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      res <= {RST_RES_HIGH, RST_RES_LOW};
    end else if (finishing) begin
      res <= fmt;
    end else begin
      if (high_we) res.high <= SFR_WDATA;
      if (low_we) res.low <= SFR_WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      steps_left <= 5'h00;
      CONV_BUSY <= 1'b0;
      CONV_DONE <= 1'b0;
    end else begin
      steps_left <= next_steps;
      CONV_BUSY <= (START_CONV && !CONV_BUSY) || (CONV_BUSY && !finishing);
      CONV_DONE <= finishing;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      SFR_RDATA <= 8'h00;
      STEP_TICK <= 1'b0;
      UNITY_GAIN <= 1'b0;
    end else begin
      SFR_RDATA <= SFR_RE ? rd_mux : 8'h00;
      STEP_TICK <= step_tick;
      UNITY_GAIN <= cfg.gain;
    end
  end

  // Assertions
  // Any divisor above zero must give a single-cycle enable
  property p_div_period;
    @(posedge CLOCK) disable iff (!RESETN)
      ($rose(step_tick) && $stable(cfg.divisor) && cfg.divisor != 5'h00)
      |=> !step_tick;
  endproperty
  a_div_period: assert property (p_div_period) else $error("tick width");

  property p_right_high;
    @(posedge CLOCK) disable iff (!RESETN)
      (finishing && !cfg.eight_bit && !cfg.left_justify)
      |=> res.high == {6'h00, $past(CONV_CODE[9:8])};
  endproperty
  a_right_high: assert property (p_right_high) else $error("rj high");

  property p_right_low;
    @(posedge CLOCK) disable iff (!RESETN)
      (finishing && !cfg.eight_bit && !cfg.left_justify)
      |=> res.low == $past(CONV_CODE[7:0]);
  endproperty
  a_right_low: assert property (p_right_low) else $error("rj low");

  property p_left_high;
    @(posedge CLOCK) disable iff (!RESETN)
      (finishing && !cfg.eight_bit && cfg.left_justify)
      |=> res.high == $past(CONV_CODE[9:2]);
  endproperty
  a_left_high: assert property (p_left_high) else $error("lj high");

  property p_left_low;
    @(posedge CLOCK) disable iff (!RESETN)
      (finishing && !cfg.eight_bit && cfg.left_justify)
      |=> res.low == {$past(CONV_CODE[1:0]), 6'h00};
  endproperty
  a_left_low: assert property (p_left_low) else $error("lj low");

  property p_eight_high;
    @(posedge CLOCK) disable iff (!RESETN)
      (finishing && cfg.eight_bit) |=> res.high == $past(CONV_CODE[9:2]);
  endproperty
  a_eight_high: assert property (p_eight_high) else $error("8b high");

  property p_eight_low;
    @(posedge CLOCK) disable iff (!RESETN)
      (finishing && cfg.eight_bit) |=> res.low == 8'h00;
  endproperty
  a_eight_low: assert property (p_eight_low) else $error("8b low");

  property p_gain;
    @(posedge CLOCK) disable iff (!RESETN)
      1'b1 |=> UNITY_GAIN == $past(cfg.gain);
  endproperty
  a_gain: assert property (p_gain) else $error("gain out");

  sequence s_start;
    START_CONV && !CONV_BUSY;
  endsequence
  property p_steps;
    @(posedge CLOCK) disable iff (!RESETN)
      s_start |=> steps_left == (cfg.eight_bit ? 5'h08 : 5'h0A);
  endproperty
  a_steps: assert property (p_steps) else $error("step count");

  property p_done;
    @(posedge CLOCK) disable iff (!RESETN)
      finishing |=> CONV_DONE && !CONV_BUSY;
  endproperty
  a_done: assert property (p_done) else $error("done pulse");
endmodule
`default_nettype wire

/* File: rtl/step_clock_divider.sv */
// Purpose: One-cycle enable at system clock divided by divisor plus one
// Assumes: Divisor may change at any time; compared with the running count at once
// Notes: Divisor 0 gives an enable every cycle
`timescale 1ns/1ps
`default_nettype none
module step_clock_divider
  import adc_fmt_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [4:0] divisor,
  output logic step_tick
);
  logic [4:0] count;
  wire wrap = (count >= divisor);
  wire [4:0] next_count = wrap ? 5'h00 : 5'(count + 5'h01);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= 5'h00;
      step_tick <= 1'b0;
    end else begin
      count <= next_count;
      step_tick <= wrap;
    end
  end
endmodule
`default_nettype wire
